// >>> hw/host_port_pkg.sv
// Constants and types shared by the host serial port block
package host_port_pkg;

   localparam int CLK_HZ         = 25_000_000;
   localparam int SPI_MAX_BPS    = 125_000;
   localparam int SPI_BYTE_CYC   = (CLK_HZ + SPI_MAX_BPS - 1) / SPI_MAX_BPS;
   localparam int SPI_SCK_MAX_HZ = 5_500_000;
   localparam int TWI_SCL_MAX_HZ = 400_000;

   // Slave address and signature header values are arbitrary
   localparam logic [6:0] TWI_ADDR_RST = 7'h2A;
   localparam logic [7:0] SIG_HDR0     = 8'hA5;
   localparam logic [7:0] SIG_HDR1     = 8'h5A;
   localparam logic [7:0] IDLE_BYTE    = 8'hFF;

   localparam logic [3:0] UART_STOP_BIT = 4'h9;
   localparam logic [3:0] TWI_ACK_SLOT  = 4'h8;
   localparam logic [3:0] TWI_ACK_END   = 4'h9;
   localparam logic [2:0] SPI_LAST_BIT  = 3'h7;
   localparam logic [1:0] SIG_LAST_IDX  = 2'h3;

   typedef enum logic [1:0] {NMEA_V21, NMEA_V23, NMEA_V40, NMEA_V41} nmea_ver_t;
   localparam nmea_ver_t NMEA_VER_RST = NMEA_V40;

   typedef enum logic [1:0] {PORT_UART, PORT_TWI, PORT_SPI} port_t;
   typedef enum logic {TX_PASS, TX_SIG} tx_state_t;
   typedef enum logic [1:0] {T_IDLE, T_ADDR, T_WR, T_RD} twi_state_t;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
      logic       sign;
   } tx_word_t;

   typedef struct packed {
      logic [7:0] data;
      port_t      port;
   } rx_word_t;

   function automatic logic rtcm_type_ok(input logic [5:0] t);
      rtcm_type_ok = (t == 6'h01) || (t == 6'h02) || (t == 6'h03)
                     || (t == 6'h09);
   endfunction : rtcm_type_ok

endpackage : host_port_pkg

// >>> hw/two_entry_buf.sv
// Small flip-flop buffer with valid and ready on both sides
`timescale 1ns/1ps
module two_entry_buf
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
)
(
   input  wire logic             i_clk,
   input  wire logic             i_srst,
   input  wire logic [WIDTH-1:0] i_in_data,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   output logic [WIDTH-1:0]      o_out_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic             push;
   logic             pop;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : bump

   assign o_in_ready  = (count != CW'(DEPTH));
   assign o_out_valid = (count != '0);
   assign o_out_data  = mem[rd_ptr];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= bump(wr_ptr);
         if (pop)
            rd_ptr <= bump(rd_ptr);
         count <= count + CW'(push) - CW'(pop);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem[i] <= '0;
      end
      else if (push)
         mem[wr_ptr] <= i_in_data;
   end

endmodule : two_entry_buf

// >>> hw/host_serial_port_select.sv
// Host port logic: serial, two-wire and four-wire ports on shared pins
`timescale 1ns/1ps
module host_serial_port_select
   import host_port_pkg::*;
#(
   parameter logic [6:0] TWI_ADDR = TWI_ADDR_RST
)
(
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_sel_pin,
   input  wire logic        i_clk_sd_pin,
   output logic             o_clk_sd_out,
   output logic             o_clk_sd_oe,
   input  wire logic        i_data_cs_pin,
   output logic             o_data_out,
   output logic             o_data_oe,
   input  wire logic        i_spi_mosi,
   output logic             o_spi_miso,
   input  wire logic        i_uart_rx,
   output logic             o_uart_tx,
   input  wire logic [15:0] i_baud_div,
   input  wire logic        i_busy,
   input  wire tx_word_t    i_tx,
   input  wire logic        i_tx_valid,
   output logic             o_tx_ready,
   input  wire logic        i_tx_to_twi,
   input  wire logic [15:0] i_sig_key,
   output rx_word_t         o_rx,
   output logic             o_rx_valid,
   input  wire logic        i_rx_ready,
   output logic             o_overrun,
   input  wire logic [5:0]  i_rtcm_type,
   output logic             o_rtcm_accept,
   input  wire nmea_ver_t   i_nmea_ver,
   input  wire logic        i_nmea_we,
   output nmea_ver_t        o_nmea_ver,
   output logic             o_spi_mode
);
   logic [3:0] meta;
   logic [3:0] sync;
   logic       scl_s;
   logic       sda_s;
   logic       urx_s;
   logic       sel_s;
   logic       scl_q;
   logic       sda_q;
   logic       urx_q;
   logic       spi_mode;
   logic       strap_done;

   // Pins come from the host's timing, so each passes two flops before the system-clock logic uses it
   always_ff @(posedge i_clk)
   begin
      meta <= {i_sel_pin, i_uart_rx, i_data_cs_pin, i_clk_sd_pin};
      sync <= meta;
      scl_q <= sync[0];
      sda_q <= sync[1];
      urx_q <= sync[2];
   end
   assign scl_s = sync[0];
   assign sda_s = sync[1];
   assign urx_s = sync[2];
   assign sel_s = sync[3];

   // Pin function is frozen until the next reset to avoid mid-frame swaps
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         strap_done <= 1'b0;
         spi_mode   <= 1'b0;
      end
      else if (!strap_done)
      begin
         strap_done <= 1'b1;
         spi_mode   <= ~sel_s;
      end
   end
   assign o_spi_mode = spi_mode;

   // Outgoing stream with appended signature frame
   tx_state_t  tx_st;
   logic [1:0] sig_idx;
   logic [7:0] sum_a;
   logic [7:0] sum_b;
   logic [7:0] sig_byte;
   logic [7:0] out_byte;
   logic       out_valid;
   logic       take;
   logic       spi_take;
   logic       uart_take;
   logic       twi_take;
   logic       twi_load;
   logic       spi_req;
   logic       ack_m;
   logic       ack_s;
   logic [7:0] rate;
   logic       utx_busy;

   assign sig_byte  = (sig_idx == 2'h0) ? SIG_HDR0 :
                      (sig_idx == 2'h1) ? SIG_HDR1 :
                      (sig_idx == 2'h2) ? sum_a : sum_b;
   assign out_byte  = (tx_st == TX_SIG) ? sig_byte : i_tx.data;
   assign out_valid = (tx_st == TX_SIG) | i_tx_valid;
   assign spi_take  = spi_mode & (spi_req == ack_s) & (rate == '0);
   assign uart_take = ~spi_mode & ~i_tx_to_twi & ~utx_busy;
   assign twi_take  = ~spi_mode & i_tx_to_twi & twi_load;
   assign take      = out_valid & (spi_take | uart_take | twi_take);
   assign o_tx_ready = (tx_st == TX_PASS) & (spi_take | uart_take | twi_take);

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         tx_st   <= TX_PASS;
         sig_idx <= '0;
         sum_a   <= i_sig_key[7:0];
         sum_b   <= i_sig_key[15:8];
      end
      else if (take && tx_st == TX_SIG)
      begin
         sig_idx <= sig_idx + 2'h1;
         if (sig_idx == SIG_LAST_IDX)
         begin
            tx_st <= TX_PASS;
            sum_a <= i_sig_key[7:0];
            sum_b <= i_sig_key[15:8];
         end
      end
      else if (take)
      begin
         if (i_tx.sign)
         begin
            sum_a <= sum_a + i_tx.data;
            sum_b <= sum_b + sum_a + i_tx.data;
         end
         if (i_tx.last && i_tx.sign)
         begin
            tx_st   <= TX_SIG;
            sig_idx <= '0;
         end
         else if (i_tx.last)
         begin
            sum_a <= i_sig_key[7:0];
            sum_b <= i_sig_key[15:8];
         end
      end
   end

   // Four-wire slave: host clock runs only inside frames
   logic       spi_cs_n;
   logic [2:0] bit_cnt;
   logic [7:0] sh_in;
   logic [7:0] sh_out;
   logic [7:0] tx_next;
   logic [7:0] spi_tx;
   logic [7:0] spi_rx;
   logic       rx_tgl;
   logic       spi_ack;
   logic       req_m;
   logic       req_s;
   logic       rxt_m;
   logic       rxt_s;
   logic       rx_seen;
   logic       spi_push;

   assign spi_cs_n   = i_data_cs_pin | ~spi_mode;
   assign o_spi_miso = (bit_cnt == '0) ? tx_next[7] : sh_out[7];

   always_ff @(posedge i_clk_sd_pin or posedge spi_cs_n)
   begin
      if (spi_cs_n)
      begin
         bit_cnt <= '0;
         sh_in   <= '0;
      end
      else
      begin
         bit_cnt <= bit_cnt + 3'h1;
         sh_in   <= {sh_in[6:0], i_spi_mosi};
      end
   end

   always_ff @(negedge i_clk_sd_pin or posedge spi_cs_n)
   begin
      if (spi_cs_n)
         sh_out <= '0;
      else if (bit_cnt == 3'h1)
         sh_out <= {tx_next[6:0], 1'b0};
      else
         sh_out <= {sh_out[6:0], 1'b0};
   end

   // A staged byte is only replaced after it has been copied into tx_next on the eighth clock of a byte
   always_ff @(posedge i_clk_sd_pin or posedge i_srst)
   begin
      if (i_srst)
      begin
         req_m   <= 1'b0;
         req_s   <= 1'b0;
         spi_ack <= 1'b0;
         rx_tgl  <= 1'b0;
         spi_rx  <= '0;
         tx_next <= IDLE_BYTE;
      end
      else
      begin
         req_m <= spi_req;
         req_s <= req_m;
         if (!spi_cs_n && bit_cnt == SPI_LAST_BIT)
         begin
            spi_rx <= {sh_in[6:0], i_spi_mosi};
            rx_tgl <= ~rx_tgl;
            if (req_s != spi_ack)
            begin
               tx_next <= spi_tx;
               spi_ack <= req_s;
            end
            else
               tx_next <= IDLE_BYTE;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         ack_m   <= 1'b0;
         ack_s   <= 1'b0;
         rxt_m   <= 1'b0;
         rxt_s   <= 1'b0;
         rx_seen <= 1'b0;
         spi_req <= 1'b0;
         spi_tx  <= IDLE_BYTE;
         rate    <= '0;
      end
      else
      begin
         ack_m   <= spi_ack;
         ack_s   <= ack_m;
         rxt_m   <= rx_tgl;
         rxt_s   <= rxt_m;
         rx_seen <= rxt_s;
         if (spi_take && out_valid)
         begin
            spi_tx  <= out_byte;
            spi_req <= ~spi_req;
            rate    <= 8'(SPI_BYTE_CYC - 1);
         end
         else if (rate != '0)
            rate <= rate - 8'h01;
      end
   end
   assign spi_push = spi_mode & (rxt_s != rx_seen);

   // Asynchronous serial port, 8N1, baud = clock / i_baud_div
   logic        urx_busy;
   logic [15:0] urx_cnt;
   logic [3:0]  urx_bit;
   logic [7:0]  urx_sh;
   logic        uart_push;
   logic [15:0] utx_cnt;
   logic [3:0]  utx_bit;
   logic [9:0]  utx_sh;

   assign uart_push = ~spi_mode & urx_busy & (urx_cnt == '0)
                      & (urx_bit == UART_STOP_BIT) & urx_s;
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         urx_busy <= 1'b0;
         urx_cnt  <= '0;
         urx_bit  <= '0;
         urx_sh   <= '0;
      end
      else if (!urx_busy && urx_q && !urx_s)
      begin
         urx_busy <= 1'b1;
         urx_cnt  <= {1'b0, i_baud_div[15:1]};
         urx_bit  <= '0;
      end
      else if (urx_busy && urx_cnt != '0)
         urx_cnt <= urx_cnt - 16'h0001;
      else if (urx_busy)
      begin
         urx_cnt <= i_baud_div - 16'h0001;
         urx_bit <= urx_bit + 4'h1;
         if ((urx_bit == '0 && urx_s) || urx_bit == UART_STOP_BIT)
            urx_busy <= 1'b0;
         else if (urx_bit != '0)
            urx_sh <= {urx_s, urx_sh[7:1]};
      end
   end

   assign o_uart_tx = utx_sh[0];
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         utx_busy <= 1'b0;
         utx_cnt  <= '0;
         utx_bit  <= '0;
         utx_sh   <= '1;
      end
      else if (uart_take && out_valid)
      begin
         utx_busy <= 1'b1;
         utx_sh   <= {1'b1, out_byte, 1'b0};
         utx_cnt  <= i_baud_div - 16'h0001;
         utx_bit  <= '0;
      end
      else if (utx_busy && utx_cnt != '0)
         utx_cnt <= utx_cnt - 16'h0001;
      else if (utx_busy)
      begin
         utx_cnt <= i_baud_div - 16'h0001;
         utx_sh  <= {1'b1, utx_sh[9:1]};
         utx_bit <= utx_bit + 4'h1;
         if (utx_bit == UART_STOP_BIT)
            utx_busy <= 1'b0;
      end
   end

   // Two-wire slave; oversampling is safe only up to the fast-mode clock
   twi_state_t twi_st;
   logic [3:0] twi_cnt;
   logic [7:0] twi_sh;
   logic       twi_rw;
   logic       twi_pend;
   logic       twi_rise;
   logic       twi_fall;
   logic       twi_start;
   logic       twi_stop;
   logic       twi_wr_slot;
   logic       twi_ok;
   logic       twi_act;
   logic       twi_push;
   logic       rx_in_ready;
   logic [7:0] twi_tx_byte;

   assign twi_rise    = scl_s & ~scl_q;
   assign twi_fall    = ~scl_s & scl_q;
   assign twi_start   = scl_s & scl_q & sda_q & ~sda_s;
   assign twi_stop    = scl_s & scl_q & ~sda_q & sda_s;
   assign twi_wr_slot = (twi_st == T_WR) & (twi_cnt == TWI_ACK_SLOT);
   assign twi_ok      = ~i_busy & ~(twi_wr_slot & (~rx_in_ready | uart_push));
   assign twi_act     = (twi_fall | twi_pend) & twi_ok & (twi_st != T_IDLE);
   assign twi_load    = twi_act & (twi_cnt == TWI_ACK_END)
                        & ((twi_st == T_RD) | ((twi_st == T_ADDR) & twi_rw));
   assign twi_push    = twi_act & twi_wr_slot;
   assign twi_tx_byte = (i_tx_to_twi && out_valid) ? out_byte : IDLE_BYTE;
   assign o_clk_sd_out = 1'b0;
   assign o_data_out   = 1'b0;
   assign o_clk_sd_oe  = twi_pend;

   always_ff @(posedge i_clk)
   begin
      if (i_srst || spi_mode)
      begin
         twi_st    <= T_IDLE;
         twi_cnt   <= '0;
         twi_sh    <= '0;
         twi_rw    <= 1'b0;
         twi_pend  <= 1'b0;
         o_data_oe <= 1'b0;
      end
      else if (twi_start || twi_stop)
      begin
         twi_st    <= twi_start ? T_ADDR : T_IDLE;
         twi_cnt   <= '0;
         twi_pend  <= 1'b0;
         o_data_oe <= 1'b0;
      end
      else if (twi_st != T_IDLE)
      begin
         twi_pend <= (twi_fall | twi_pend) & ~twi_ok;
         if (twi_rise && twi_cnt < TWI_ACK_SLOT)
         begin
            twi_cnt <= twi_cnt + 4'h1;
            if (twi_st != T_RD)
               twi_sh <= {twi_sh[6:0], sda_s};
         end
         else if (twi_rise && twi_cnt == TWI_ACK_SLOT)
         begin
            twi_cnt <= TWI_ACK_END;
            if (twi_st == T_RD && sda_s)
               twi_st <= T_IDLE;
         end
         else if (twi_act && twi_cnt == TWI_ACK_SLOT)
         begin
            if (twi_st == T_ADDR && twi_sh[7:1] == TWI_ADDR)
            begin
               o_data_oe <= 1'b1;
               twi_rw    <= twi_sh[0];
            end
            else if (twi_st == T_ADDR)
               twi_st <= T_IDLE;
            else
               o_data_oe <= (twi_st == T_WR);
         end
         else if (twi_load)
         begin
            twi_st    <= T_RD;
            twi_cnt   <= '0;
            twi_sh    <= twi_tx_byte;
            o_data_oe <= ~twi_tx_byte[7];
         end
         else if (twi_act && twi_cnt == TWI_ACK_END)
         begin
            twi_st    <= T_WR;
            twi_cnt   <= '0;
            o_data_oe <= 1'b0;
         end
         else if (twi_act && twi_st == T_RD && twi_cnt != '0)
         begin
            twi_sh    <= {twi_sh[6:0], 1'b0};
            o_data_oe <= ~twi_sh[6];
         end
      end
   end

   // Ports are byte pipes, so every protocol passes on every port
   rx_word_t buf_in;
   logic     buf_valid;

   assign buf_in.data = spi_push ? spi_rx :
                        uart_push ? urx_sh : twi_sh;
   assign buf_in.port = spi_push ? PORT_SPI :
                        uart_push ? PORT_UART : PORT_TWI;
   assign buf_valid   = spi_push | uart_push | twi_push;

   two_entry_buf #(
      .WIDTH ($bits(rx_word_t)),
      .DEPTH (2)
   ) u_rx_buf (
      .i_clk       (i_clk),
      .i_srst      (i_srst),
      .i_in_data   (buf_in),
      .i_in_valid  (buf_valid),
      .o_in_ready  (rx_in_ready),
      .o_out_data  (o_rx),
      .o_out_valid (o_rx_valid),
      .i_out_ready (i_rx_ready)
   );

   // Only the serial and four-wire receivers can lose a byte
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_overrun     <= 1'b0;
         o_rtcm_accept <= 1'b0;
         o_nmea_ver    <= NMEA_VER_RST;
      end
      else
      begin
         o_overrun     <= (spi_push | uart_push) & ~rx_in_ready;
         o_rtcm_accept <= rtcm_type_ok(i_rtcm_type);
         if (i_nmea_we)
            o_nmea_ver <= i_nmea_ver;
      end
   end

endmodule : host_serial_port_select

// >>> bench/host_port_monitor.sv
// Pin-level checker for the host port block
`timescale 1ns/1ps
module host_port_monitor
   import host_port_pkg::*;
(
   input wire logic       i_clk,
   input wire logic       i_srst,
   input wire logic       i_clk_sd_pin,
   input wire logic       o_clk_sd_out,
   input wire logic       o_clk_sd_oe,
   input wire logic       o_data_out,
   input wire logic       o_data_oe,
   input wire logic       o_uart_tx,
   input wire logic       i_busy,
   input wire logic       i_tx_valid,
   input wire logic       o_tx_ready,
   input wire logic       i_tx_to_twi,
   input wire logic       o_rx_valid,
   input wire logic       o_overrun,
   input wire logic [5:0] i_rtcm_type,
   input wire logic       o_rtcm_accept,
   input wire nmea_ver_t  i_nmea_ver,
   input wire logic       i_nmea_we,
   input wire nmea_ver_t  o_nmea_ver,
   input wire logic       o_spi_mode
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   wire logic ser_take = i_tx_valid && o_tx_ready && !o_spi_mode
                         && !i_tx_to_twi;
   int        spi_gap;
   // Cycles since the last four-wire byte was taken, saturating
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         spi_gap <= SPI_BYTE_CYC;
      else if (i_tx_valid && o_tx_ready && o_spi_mode)
         spi_gap <= 0;
      else if (spi_gap < SPI_BYTE_CYC)
         spi_gap <= spi_gap + 1;
   end
   a_spi_rate: assert property (
      i_tx_valid && o_tx_ready && o_spi_mode |-> spi_gap >= SPI_BYTE_CYC - 1)
      else $error("four-wire byte rate too high");
   a_reset_vals: assert property (
      $fell(i_srst) |-> o_nmea_ver == NMEA_V40 && !o_spi_mode && o_uart_tx
         && !o_rx_valid && !o_clk_sd_oe) else $error("bad reset value");
   a_rtcm_types: assert property (!$past(i_srst) |-> o_rtcm_accept ==
      ($past(i_rtcm_type) inside {6'h01, 6'h02, 6'h03, 6'h09}))
      else $error("correction type filter wrong");
   a_nmea_write: assert property (
      i_nmea_we |=> o_nmea_ver == $past(i_nmea_ver)) else $error("ver write");
   a_nmea_hold: assert property (
      !$past(i_nmea_we) && !$past(i_srst) |-> $stable(o_nmea_ver))
      else $error("ver changed unasked");
   a_mode_fixed: assert property (
      !$past(i_srst) && !$past(i_srst, 2) && !$past(i_srst, 3)
      |-> $stable(o_spi_mode)) else $error("mode changed after start");
   a_spi_pins_free: assert property (
      o_spi_mode |-> !o_clk_sd_oe && !o_data_oe) else $error("pins driven");
   a_stretch_busy: assert property (
      !o_spi_mode && i_busy && $fell(i_clk_sd_pin) |-> ##[1:6] o_clk_sd_oe)
      else $error("no clock stretch");
   a_uart_start: assert property (
      ser_take |=> (!o_uart_tx && !o_tx_ready) ##1 !o_tx_ready [*7])
      else $error("serial start wrong");
   a_overrun_pulse: assert property (
      o_overrun |=> !o_overrun) else $error("overrun not a pulse");
   a_od_zero: assert property (
      !o_clk_sd_out && !o_data_out) else $error("open drain drives high");
   c_stretch: cover property (o_clk_sd_oe && !o_spi_mode);
   c_ser_take: cover property (ser_take);
   c_overrun: cover property (o_overrun);
endmodule : host_port_monitor

bind host_serial_port_select host_port_monitor u_mon (
   .i_clk(i_clk), .i_srst(i_srst), .i_clk_sd_pin(i_clk_sd_pin),
   .o_clk_sd_out(o_clk_sd_out), .o_clk_sd_oe(o_clk_sd_oe),
   .o_data_out(o_data_out), .o_data_oe(o_data_oe), .o_uart_tx(o_uart_tx),
   .i_busy(i_busy), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
   .i_tx_to_twi(i_tx_to_twi), .o_rx_valid(o_rx_valid),
   .o_overrun(o_overrun), .i_rtcm_type(i_rtcm_type),
   .o_rtcm_accept(o_rtcm_accept), .i_nmea_ver(i_nmea_ver),
   .i_nmea_we(i_nmea_we), .o_nmea_ver(o_nmea_ver), .o_spi_mode(o_spi_mode));

// >>> bench/host_model.sv
// Behavioural host: master on the shared pins and serial line
`timescale 1ns/1ps
module host_model
(
   input  wire logic i_clk,
   input  wire logic i_pin6,
   input  wire logic i_pin3,
   input  wire logic i_miso,
   output logic      o_pin6_rel,
   output logic      o_pin3_rel,
   output logic      o_mosi,
   output logic      o_txd
);
   initial
   begin
      o_pin6_rel = 1'b1;
      o_pin3_rel = 1'b1;
      o_mosi = 1'b0;
      o_txd = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask : tick
   task automatic spi_cs(input logic sel_n);
      o_pin6_rel <= 1'b0;
      o_pin3_rel <= sel_n;
   endtask : spi_cs
   // 96 ns half period: 5.2 MHz link clock, free of the system clock
   task automatic spi_byte(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
      begin
         o_mosi = b[i];
         #96 o_pin6_rel = 1'b1;
         r[i] = i_miso;
         #96 o_pin6_rel = 1'b0;
      end
      o_mosi = ~b[0];
   endtask : spi_byte
   // Releasing the clock is not enough: the device may hold it low
   task automatic scl_up();
      o_pin6_rel <= 1'b1;
      for (int n = 0; n < 4000 && i_pin6 !== 1'b1; n++) tick(1);
      tick(21);
   endtask : scl_up
   // At least 63 cycles a bit keeps the clock under 400 kHz
   task automatic i2c_bit(input logic b, output logic r);
      o_pin3_rel <= b;
      tick(42);
      scl_up();
      r = i_pin3;
      o_pin6_rel <= 1'b0;
   endtask : i2c_bit
   task automatic i2c_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) i2c_bit(b[i], r);
      i2c_bit(1'b1, r);
      ack = !r;
   endtask : i2c_byte
   task automatic i2c_write(input logic [6:0] a, input logic [7:0] d,
                            output logic ack);
      logic k;
      o_pin3_rel <= 1'b1;
      o_pin6_rel <= 1'b1;
      tick(42);
      o_pin3_rel <= 1'b0;
      tick(21);
      o_pin6_rel <= 1'b0;
      i2c_byte({a, 1'b0}, ack);
      if (ack) i2c_byte(d, k);
      o_pin3_rel <= 1'b0;
      tick(42);
      scl_up();
      o_pin3_rel <= 1'b1;
      tick(42);
   endtask : i2c_write
   task automatic uart_send(input logic [7:0] b, input int div);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         o_txd <= f[i];
         tick(div);
      end
   endtask : uart_send
endmodule : host_model

// >>> bench/tb_top.sv
// Self-checking bench for the host port block
`timescale 1ns/1ps
module tb_top
   import host_port_pkg::*;
   ;
   localparam logic [15:0] DIV = 16'h0008;
   localparam logic [15:0] KEY = 16'h3C21;
   localparam logic [5:0] RT [8] = '{6'h01, 6'h02, 6'h03, 6'h09,
                                     6'h00, 6'h04, 6'h0A, 6'h3F};
   localparam logic [7:0] RA = 8'h0F;
   logic clk, srst, sel, busy, tx_valid, rx_ready, nmea_we, ovr, strd;
   logic [5:0] rtcm;
   logic [7:0] got, sa, sb;
   logic [39:0] sig;
   logic ack;
   nmea_ver_t nmea_ver, ver_o;
   tx_word_t tx;
   rx_word_t rx;
   wire logic p6_rel, p3_rel, mosi, txd, scl_oe, sda_oe, miso, utx;
   wire logic tx_ready, rx_valid, overrun, accept, spi_mode;
   wire logic pin6 = p6_rel & ~scl_oe;
   wire logic pin3 = p3_rel & ~sda_oe;
   int errors, n_tests;
   host_serial_port_select dut (.i_clk(clk), .i_srst(srst),
      .i_sel_pin(sel), .i_clk_sd_pin(pin6), .o_clk_sd_out(),
      .o_clk_sd_oe(scl_oe), .i_data_cs_pin(pin3), .o_data_out(),
      .o_data_oe(sda_oe), .i_spi_mosi(mosi), .o_spi_miso(miso),
      .i_uart_rx(txd), .o_uart_tx(utx), .i_baud_div(DIV), .i_busy(busy),
      .i_tx(tx), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
      .i_tx_to_twi(1'b0), .i_sig_key(KEY), .o_rx(rx), .o_rx_valid(rx_valid),
      .i_rx_ready(rx_ready), .o_overrun(overrun), .i_rtcm_type(rtcm),
      .o_rtcm_accept(accept), .i_nmea_ver(nmea_ver), .i_nmea_we(nmea_we),
      .o_nmea_ver(ver_o), .o_spi_mode(spi_mode));
   host_model host (.i_clk(clk), .i_pin6(pin6), .i_pin3(pin3),
      .i_miso(miso), .o_pin6_rel(p6_rel), .o_pin3_rel(p3_rel),
      .o_mosi(mosi), .o_txd(txd));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (overrun === 1'b1) ovr <= 1'b1;
      if (scl_oe === 1'b1) strd <= 1'b1;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("comparisons %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task automatic do_reset(input logic s);
      sel <= s;
      srst <= 1'b1;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : do_reset
   task automatic pop(input logic [7:0] d, input port_t p);
      for (int n = 0; n < 3000 && rx_valid !== 1'b1; n++) @(posedge clk);
      check(rx, {d, p});
      rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
      @(posedge clk);
   endtask : pop
   task automatic send(input logic [7:0] d, input logic l, input logic s);
      tx <= {d, l, s};
      tx_valid <= 1'b1;
      @(posedge clk);
      for (int n = 0; n < 5000 && tx_ready !== 1'b1; n++) @(posedge clk);
      tx_valid <= 1'b0;
   endtask : send
   task automatic uart_get(output logic [7:0] b);
      for (int n = 0; n < 2000 && utx !== 1'b0; n++) @(posedge clk);
      repeat (DIV + DIV / 2 - 1) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         b[i] = utx;
         repeat (DIV) @(posedge clk);
      end
   endtask : uart_get
   initial
   begin
      #2_000_000;
      errors++;
      end_sim();
   end
   initial
   begin
      {srst, sel, busy, tx_valid, rx_ready, nmea_we, ovr, strd} = 8'h80;
      {rtcm, nmea_ver, tx, errors, n_tests} = '0;
      do_reset(1'b0);
      check(spi_mode, 1'b1);
      send(8'h5C, 1'b0, 1'b0);
      host.spi_cs(1'b0);
      host.spi_byte(8'hC3, got);
      host.spi_cs(1'b1);
      check(got, IDLE_BYTE);
      send(8'h6D, 1'b0, 1'b0);
      host.spi_cs(1'b0);
      host.spi_byte(8'h96, got);
      host.spi_cs(1'b1);
      check(got, 8'h5C);
      pop(8'hC3, PORT_SPI);
      pop(8'h96, PORT_SPI);
      do_reset(1'b1);
      check(spi_mode, 1'b0);
      check(ver_o, NMEA_V40);
      sel <= 1'b0;
      repeat (10) @(posedge clk);
      check(spi_mode, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         rtcm <= RT[i];
         nmea_ver <= nmea_ver_t'(i[1:0]);
         nmea_we <= 1'b1;
         @(posedge clk);
         nmea_we <= 1'b0;
         @(posedge clk);
         check(accept, RA[i]);
         check(ver_o, i[1:0]);
      end
      sa = KEY[7:0] + 8'h12;
      sb = KEY[15:8] + sa;
      send(8'h12, 1'b0, 1'b1);
      uart_get(got);
      check(got, 8'h12);
      sa = sa + 8'h37;
      sb = sb + sa;
      sig = {8'h37, SIG_HDR0, SIG_HDR1, sa, sb};
      send(8'h37, 1'b1, 1'b1);
      for (int k = 4; k >= 0; k--)
      begin
         uart_get(got);
         check(got, sig[8*k +: 8]);
      end
      host.uart_send(8'hA1, DIV);
      host.uart_send(8'hB2, DIV);
      host.uart_send(8'hC4, DIV);
      repeat (DIV * 4) @(posedge clk);
      check(ovr, 1'b1);
      pop(8'hA1, PORT_UART);
      pop(8'hB2, PORT_UART);
      busy <= 1'b1;
      fork
         host.i2c_write(TWI_ADDR_RST, 8'h5A, ack);
         begin
            repeat (400) @(posedge clk);
            busy <= 1'b0;
         end
      join
      check(ack, 1'b1);
      check(strd, 1'b1);
      pop(8'h5A, PORT_TWI);
      host.i2c_write(TWI_ADDR_RST + 7'h01, 8'h00, ack);
      check(ack, 1'b0);
      end_sim();
   end
endmodule : tb_top
